// ---- verilog/dasp_pkg.sv ----
// Constants for the dual audio serial port
package dasp_pkg;
    // Register byte offsets
    localparam logic [7:0] MAIN_FMT_OFF   = 8'h00;
    localparam logic [7:0] SAMP_CFG_OFF   = 8'h04;
    localparam logic [7:0] MAIN_CTL_OFF   = 8'h08;
    localparam logic [7:0] AUX_CFG_OFF    = 8'h0C;
    localparam logic [7:0] AUX_CTL_OFF    = 8'h10;
    localparam logic [7:0] MAIN_TXL_OFF   = 8'h14;
    localparam logic [7:0] MAIN_TXR_OFF   = 8'h18;
    localparam logic [7:0] MAIN_RXL_OFF   = 8'h1C;
    localparam logic [7:0] MAIN_RXR_OFF   = 8'h20;
    localparam logic [7:0] AUX_TX_OFF     = 8'h24;
    localparam logic [7:0] AUX_RX_OFF     = 8'h28;
    localparam logic [7:0] STATUS_OFF     = 8'h2C;
    // Main format fields
    localparam int FMT_POL_BIT   = 0;
    localparam int FMT_LJ_BIT    = 1;
    localparam int FMT_IIS_BIT   = 2;
    // Main control fields
    localparam int CTL_RX_BIT    = 0;
    localparam int CTL_TX_BIT    = 1;
    localparam int CTL_MS_BIT    = 2;
    // Aux config fields
    localparam int AUX_SYNC_BIT  = 0;
    localparam int AUX_INV_BIT   = 1;
    localparam int AUX_WID_LSB   = 4;
    localparam int AUX_CH_LSB    = 8;
    // Reset values
    localparam logic [2:0] FMT_RST       = 3'h0;
    localparam logic [4:0] FLEN_RST      = 5'h1F;
    localparam logic [2:0] CTL_RST       = 3'h0;
    localparam logic [1:0] AUX_WID_RST   = 2'h1;
    localparam logic [3:0] AUX_CH_RST    = 4'h2;
    // Frame length codes: half-frame bits = code + 1
    localparam logic [4:0] FLEN_MIN      = 5'h0F;
    localparam logic [4:0] FLEN_32       = 5'h0F;
    localparam logic [4:0] FLEN_64       = 5'h1F;
    localparam int         SAMPLE_W      = 16;
    // Master bit clock half period in hclk cycles
    localparam logic [3:0] BCLK_HALF     = 4'h4;
    // Aux widths: code 0..3 = 32,64,128,256 bit clocks per frame
    localparam logic [1:0] AUX_W128      = 2'h2;
endpackage

// ---- verilog/dasp_lane.sv ----
// One serial lane: clock generation or sampling, shifting in and out
`timescale 1ns/10ps
module dasp_lane (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Configuration
    input  wire logic        master,
    input  wire logic        run,
    input  wire logic        invert,
    input  wire logic [8:0]  slot_bits,
    input  wire logic [8:0]  frame_bits,
    input  wire logic [8:0]  data_start,
    input  wire logic [8:0]  data_end,
    input  wire logic        fs_pulse,
    input  wire logic        fs_lead,
    // Pins
    input  wire logic        bclk_in,
    input  wire logic        fs_in,
    output logic             bclk_out,
    output logic             fs_out,
    input  wire logic        sd_in,
    // Frame data
    input  wire logic [15:0] tx_word,
    output logic             sd_bit,
    output logic [15:0]      rx_word,
    output logic             rx_done,
    output logic [8:0]       bit_pos,
    output logic             frame_start
);
    import dasp_pkg::*;

    logic [1:0]  bclk_s_r;
    logic [1:0]  fs_s_r;
    logic        bclk_d_r;
    logic        fs_d_r;
    logic [3:0]  div_r;
    logic        aux_bit_clock_r;
    logic [8:0]  pos_r;
    logic [15:0] sh_r;
    logic [15:0] rx_r;
    logic        sd_r;
    logic        rxd_r;
    logic        fall_d_r;
    logic        dv_r;
    logic        dl_r;

    ////////////////////////////////////////////////////////////////
    wire bclk_i    = master ? aux_bit_clock_r : bclk_s_r[1];
    wire bclk_eff  = invert ? ~bclk_i : bclk_i;
    wire fs_i      = master ? fs_out : fs_s_r[1];
    wire div_end   = (div_r == BCLK_HALF - 4'h1);
    wire mfall     = master && run && div_end && aux_bit_clock_r;
    wire bclk_del  = invert ? ~bclk_d_r : bclk_d_r;
    wire rise      = run && bclk_eff && !bclk_del;
    wire fall      = run && !bclk_eff && bclk_del;
    wire fs_is_lead = (fs_s_r[1] == fs_lead);
    wire s_fs_edge = !master && (fs_s_r[1] != fs_d_r) && (!fs_pulse || fs_is_lead);
    wire in_data   = (pos_r >= data_start) && (pos_r <= data_end);
    // Slave edge: leading level starts the frame, the other starts the second half
    wire [8:0] fs_jump = fs_is_lead ? 9'h000 : slot_bits;
    wire [8:0] pos_nxt = s_fs_edge ? fs_jump
                       : ((pos_r == frame_bits - 9'h001) ? 9'h000 : pos_r + 9'h001);

    assign bclk_out    = run ? aux_bit_clock_r : 1'b0;
    assign bit_pos     = pos_r;
    assign frame_start = fall && (pos_nxt == 9'h000);
    assign sd_bit      = sd_r;
    assign rx_word     = rx_r;
    assign rx_done     = rxd_r;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bclk_s_r <= 2'h0;
            fs_s_r   <= 2'h0;
            bclk_d_r <= 1'b0;
            fs_d_r   <= 1'b0;
            fall_d_r <= 1'b0;
        end else begin
            bclk_s_r <= {bclk_s_r[0], bclk_in};
            fs_s_r   <= {fs_s_r[0], fs_in};
            bclk_d_r <= bclk_i;
            fs_d_r   <= fs_s_r[1];
            fall_d_r <= fall;
        end
    end

    // Master clock divider, held low while idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r   <= 4'h0;
            aux_bit_clock_r <= 1'b0;
        end else if (!master || !run) begin
            div_r   <= 4'h0;
            aux_bit_clock_r <= 1'b0;
        end else if (div_end) begin
            div_r   <= 4'h0;
            aux_bit_clock_r <= ~aux_bit_clock_r;
        end else begin
            div_r   <= div_r + 4'h1;
        end
    end

    // shift out on falling edge, MSB first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r  <= 9'h000;
            sh_r   <= 16'h0000;
            sd_r   <= 1'b0;
            dv_r   <= 1'b0;
            dl_r   <= 1'b0;
            fs_out <= 1'b0;
        end else if (!run) begin
            pos_r  <= 9'h000;
            sd_r   <= 1'b0;
            dv_r   <= 1'b0;
            dl_r   <= 1'b0;
            fs_out <= 1'b0;
        end else begin
            if (fall) begin
                pos_r <= pos_nxt;
                if (master) begin
                    fs_out <= fs_pulse ? (pos_nxt == 9'h000)
                                       : (pos_nxt >= slot_bits);
                end
            end else if (s_fs_edge) begin
                pos_r <= fs_jump;
            end
            // One cycle after the edge, so the window matches the new position
            if (fall_d_r) begin
                dv_r <= in_data;
                dl_r <= in_data && (pos_r == data_end);
                if (!in_data) begin
                    sd_r <= 1'b0;
                end else if (pos_r == data_start) begin
                    sd_r <= tx_word[15];
                    sh_r <= {tx_word[14:0], 1'b0};
                end else begin
                    sd_r <= sh_r[15];
                    sh_r <= {sh_r[14:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_r  <= 16'h0000;
            rxd_r <= 1'b0;
        end else begin
            rxd_r <= 1'b0;
            if (rise && dv_r) begin
                rx_r  <= {rx_r[14:0], sd_in};
                rxd_r <= dl_r;
            end
        end
    end

    wire unused_fs = fs_i;
endmodule // dasp_lane

// ---- verilog/dasp_top.sv ----
// Dual audio serial port: main stereo port and aux core port with AHB-Lite registers
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module dasp_top (
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Main audio port
    input  wire logic        main_bclk_i,
    output logic             main_bclk_o,
    output logic             main_bclk_oe_n,
    input  wire logic        main_fclk_i,
    output logic             main_fclk_o,
    output logic             main_fclk_oe_n,
    input  wire logic        main_serial_in,
    output logic             main_serial_out,
    output logic             main_serial_out_oe_n,
    // Aux core port
    input  wire logic        aux_bit_clock_i,
    output logic             aux_bit_clock_o,
    output logic             aux_bit_clock_oe_n,
    input  wire logic        aux_frame_sync_i,
    output logic             aux_frame_sync_o,
    output logic             aux_frame_sync_oe_n,
    input  wire logic        aux_serial_in,
    output logic             aux_serial_out,
    output logic             aux_serial_out_oe_n
);
    import dasp_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0]  main_port_format_reg_r;
    logic [4:0]  frame_length_field_r;
    logic [2:0]  main_ctl_r;
    logic        aux_sync_mode_bit_r;
    logic        aux_clock_invert_bit_r;
    logic [1:0]  aux_bit_width_field_r;
    logic [3:0]  aux_channel_count_r;
    logic [2:0]  aux_ctl_r;
    logic [15:0] main_txl_r;
    logic [15:0] main_txr_r;
    logic [15:0] main_rxl_r;
    logic [15:0] main_rxr_r;
    logic [15:0] aux_tx_r;
    logic [15:0] aux_rx_r;
    logic [3:0]  aux_rx_slot_r;
    logic        main_ovr_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        rd_pend_r;
    logic [31:0] hrdata_r;

    ////////////////////////////////////////////////////////////////
    // Bus decode
    wire       xfer     = hsel && hready && htrans[1];
    wire [7:0] a_off    = {haddr[7:2], 2'b00};
    wire       wr_en    = wr_pend_r;
    wire       wr_fmt   = wr_en && (wr_addr_r == MAIN_FMT_OFF);
    wire       wr_samp  = wr_en && (wr_addr_r == SAMP_CFG_OFF);
    wire       wr_mctl  = wr_en && (wr_addr_r == MAIN_CTL_OFF);
    wire       wr_acfg  = wr_en && (wr_addr_r == AUX_CFG_OFF);
    wire       wr_actl  = wr_en && (wr_addr_r == AUX_CTL_OFF);
    wire       wr_txl   = wr_en && (wr_addr_r == MAIN_TXL_OFF);
    wire       wr_txr   = wr_en && (wr_addr_r == MAIN_TXR_OFF);
    wire       wr_atx   = wr_en && (wr_addr_r == AUX_TX_OFF);
    wire       wr_stat  = wr_en && (wr_addr_r == STATUS_OFF);

    ////////////////////////////////////////////////////////////////
    // Main port configuration
    wire       m_rx     = main_ctl_r[CTL_RX_BIT];
    wire       m_tx     = main_ctl_r[CTL_TX_BIT];
    wire       m_master = main_ctl_r[CTL_MS_BIT];
    wire       m_run    = m_rx || m_tx;
    wire       m_pol    = main_port_format_reg_r[FMT_POL_BIT];
    wire       m_lj     = main_port_format_reg_r[FMT_LJ_BIT];
    wire       m_iis    = main_port_format_reg_r[FMT_IIS_BIT];
    // slave lengths multiples of 4 from 32 to 64
    wire       flen_ok_s = (frame_length_field_r >= FLEN_MIN) && frame_length_field_r[0];
    // master restricted to 32 or 64
    wire       flen_ok_m = (frame_length_field_r == FLEN_32)
                        || (frame_length_field_r == FLEN_64);
    wire [4:0] flen_use = (m_master ? flen_ok_m : flen_ok_s)
                        ? frame_length_field_r : FLEN_RST;
    wire [8:0] m_slot   = {4'h0, flen_use} + 9'h001;
    wire [8:0] m_frame  = {m_slot[7:0], 1'b0};
    wire [8:0] m_pos;
    wire       m_second = (m_pos >= m_slot);
    wire [8:0] m_hpos   = m_second ? m_pos - m_slot : m_pos;
    // IIS is one empty bit after the edge
    wire [8:0] m_off    = m_iis ? 9'h001
                        : (m_lj ? 9'h000 : m_slot - 9'(SAMPLE_W));
    wire [8:0] m_start  = m_second ? m_slot + m_off : m_off;
    wire [8:0] m_end    = m_start + 9'(SAMPLE_W - 1);
    wire       m_hi_first = 1'b1;
    // polarity 0 left in high phase except in IIS
    // polarity swaps channel order in LR mode
    wire       m_left   = m_iis ? !m_second : (m_pol ? m_second : !m_second);
    wire [15:0] m_txw   = m_left ? main_txl_r : main_txr_r;
    wire       m_fclk_raw;
    wire       m_sd;
    wire [15:0] m_rxw;
    wire       m_rxd;
    wire       m_fstart;
    wire       m_bclk_raw;
    // Left half-frame (first) leads with frame clock high unless IIS or swapped
    wire       m_fclk_inv = m_iis || m_pol;

    dasp_lane u_main (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .master      (m_master),
        .run         (m_run),
        .invert      (1'b0),
        .slot_bits   (m_slot),
        .frame_bits  (m_frame),
        .data_start  (m_start),
        .data_end    (m_end),
        .fs_pulse    (1'b0),
        .fs_lead     (!m_fclk_inv),
        .bclk_in     (main_bclk_i),
        .fs_in       (main_fclk_i),
        .bclk_out    (m_bclk_raw),
        .fs_out      (m_fclk_raw),
        .sd_in       (main_serial_in),
        .tx_word     (m_txw),
        .sd_bit      (m_sd),
        .rx_word     (m_rxw),
        .rx_done     (m_rxd),
        .bit_pos     (m_pos),
        .frame_start (m_fstart)
    );

    // idle master clocks low, outputs only in master
    assign main_bclk_o     = m_bclk_raw;
    assign main_fclk_o     = m_run && (m_fclk_raw ^ ~m_fclk_inv ^ ~m_hi_first);
    assign main_bclk_oe_n  = !m_master;
    assign main_fclk_oe_n  = !m_master;
    // drive serial out only on transmit
    assign main_serial_out      = m_tx ? m_sd : 1'b0;
    assign main_serial_out_oe_n = !m_tx;

    ////////////////////////////////////////////////////////////////
    // Aux port configuration
    wire       a_rx     = aux_ctl_r[CTL_RX_BIT];
    wire       a_tx     = aux_ctl_r[CTL_TX_BIT];
    wire       a_master = aux_ctl_r[CTL_MS_BIT];
    wire       a_run    = a_rx || a_tx;
    // width codes 32..256, channels per frame
    wire [8:0] a_frame  = 9'h020 << aux_bit_width_field_r;
    wire [8:0] a_chs    = {5'h00, aux_channel_count_r};
    wire [8:0] a_slot   = (a_chs == 9'h000) ? a_frame : a_frame / a_chs;
    wire [8:0] a_pos;
    // Slot k covers base+1 to base+16, so index by the previous position
    wire [8:0] a_rel    = (a_pos == 9'h000) ? a_frame - 9'h001 : a_pos - 9'h001;
    wire [8:0] a_idx    = (a_slot == 9'h000) ? 9'h000 : a_rel / a_slot;
    wire [8:0] a_base   = a_idx * a_slot;
    wire [8:0] a_start  = a_base + 9'h001;
    wire [8:0] a_end    = a_start + 9'(SAMPLE_W - 1);
    wire       a_fsraw;
    wire       a_sd;
    wire [15:0] a_rxw;
    wire       a_rxd;
    wire       a_bclk_raw;

    // mode, width and inversion from registers
    dasp_lane u_aux (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .master      (a_master),
        .run         (a_run),
        .invert      (aux_clock_invert_bit_r),
        .slot_bits   (a_frame >> 1),
        .frame_bits  (a_frame),
        .data_start  (a_start),
        .data_end    (a_end),
        .fs_pulse    (!aux_sync_mode_bit_r),
        .fs_lead     (!aux_sync_mode_bit_r),
        .bclk_in     (aux_bit_clock_i),
        .fs_in       (aux_frame_sync_i),
        .bclk_out    (a_bclk_raw),
        .fs_out      (a_fsraw),
        .sd_in       (aux_serial_in),
        .tx_word     (aux_tx_r),
        .sd_bit      (a_sd),
        .rx_word     (a_rxw),
        .rx_done     (a_rxd),
        .bit_pos     (a_pos),
        .frame_start ()
    );

    // aux pins gated like main port
    assign aux_bit_clock_o     = a_run && (a_bclk_raw ^ aux_clock_invert_bit_r);
    assign aux_bit_clock_oe_n  = !a_master;
    assign aux_frame_sync_o    = a_run && a_fsraw;
    assign aux_frame_sync_oe_n = !a_master;
    assign aux_serial_out      = a_tx ? a_sd : 1'b0;
    assign aux_serial_out_oe_n = !a_tx;

    ////////////////////////////////////////////////////////////////
    // Read mux
    wire [31:0] rd_mux =
        (a_off == MAIN_FMT_OFF) ? {29'h0, main_port_format_reg_r} :
        (a_off == SAMP_CFG_OFF) ? {27'h0, frame_length_field_r} :
        (a_off == MAIN_CTL_OFF) ? {29'h0, main_ctl_r} :
        (a_off == AUX_CFG_OFF)  ? {20'h0, aux_channel_count_r, 2'h0,
                                   aux_bit_width_field_r, 2'h0,
                                   aux_clock_invert_bit_r, aux_sync_mode_bit_r} :
        (a_off == AUX_CTL_OFF)  ? {29'h0, aux_ctl_r} :
        (a_off == MAIN_TXL_OFF) ? {16'h0, main_txl_r} :
        (a_off == MAIN_TXR_OFF) ? {16'h0, main_txr_r} :
        (a_off == MAIN_RXL_OFF) ? {16'h0, main_rxl_r} :
        (a_off == MAIN_RXR_OFF) ? {16'h0, main_rxr_r} :
        (a_off == AUX_TX_OFF)   ? {16'h0, aux_tx_r} :
        (a_off == AUX_RX_OFF)   ? {12'h0, aux_rx_slot_r, aux_rx_r} :
        (a_off == STATUS_OFF)   ? {30'h0, m_second, main_ovr_r} : 32'h0;

    assign hrdata    = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_pend_r <= 1'b0;
            hrdata_r  <= 32'h0;
        end else begin
            wr_pend_r <= xfer && hwrite;
            wr_addr_r <= a_off;
            rd_pend_r <= xfer && !hwrite;
            if (xfer && !hwrite) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_port_format_reg_r <= FMT_RST;
            frame_length_field_r   <= FLEN_RST;
            main_ctl_r             <= CTL_RST;
            aux_ctl_r              <= CTL_RST;
            aux_sync_mode_bit_r    <= 1'b0;
            aux_clock_invert_bit_r <= 1'b0;
            aux_bit_width_field_r  <= AUX_WID_RST;
            aux_channel_count_r    <= AUX_CH_RST;
            main_txl_r             <= 16'h0000;
            main_txr_r             <= 16'h0000;
            aux_tx_r               <= 16'h0000;
        end else begin
            if (wr_fmt) main_port_format_reg_r <= hwdata[2:0];
            if (wr_samp) frame_length_field_r <= hwdata[4:0];
            if (wr_mctl) main_ctl_r <= hwdata[2:0];
            if (wr_actl) aux_ctl_r <= hwdata[2:0];
            if (wr_acfg) begin
                aux_sync_mode_bit_r    <= hwdata[AUX_SYNC_BIT];
                aux_clock_invert_bit_r <= hwdata[AUX_INV_BIT];
                aux_bit_width_field_r  <= hwdata[AUX_WID_LSB +: 2];
                aux_channel_count_r    <= hwdata[AUX_CH_LSB +: 4];
            end
            if (wr_txl) main_txl_r <= hwdata[15:0];
            if (wr_txr) main_txr_r <= hwdata[15:0];
            if (wr_atx) aux_tx_r <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_rxl_r    <= 16'h0000;
            main_rxr_r    <= 16'h0000;
            aux_rx_r      <= 16'h0000;
            aux_rx_slot_r <= 4'h0;
            main_ovr_r    <= 1'b0;
        end else begin
            if (m_rxd && m_rx) begin
                if (m_left) main_rxl_r <= m_rxw;
                else main_rxr_r <= m_rxw;
            end
            if (a_rxd && a_rx) begin
                aux_rx_r      <= a_rxw;
                aux_rx_slot_r <= a_idx[3:0];
            end
            // Frame wrap flag, set beats clear
            if (m_fstart && m_run) main_ovr_r <= 1'b1;
            else if (wr_stat && hwdata[0]) main_ovr_r <= 1'b0;
        end
    end

    wire unused_ok = rd_pend_r ^ (|hsize) ^ (|haddr[31:8]) ^ (|haddr[1:0]);
endmodule // dasp_top

// ---- verif/dasp_props.sv ----
// Port checker for the dual audio serial port
`timescale 1ns/10ps
module dasp_props (
    // Clock and reset
    input logic hclk,
    input logic hresetn,
    // Bus answer
    input logic hreadyout,
    input logic hresp,
    // Main port pins
    input logic main_bclk_o,
    input logic main_bclk_oe_n,
    input logic main_fclk_o,
    input logic main_fclk_oe_n,
    input logic main_serial_out,
    input logic main_serial_out_oe_n,
    // Aux port pins
    input logic aux_bit_clock_o,
    input logic aux_bit_clock_oe_n,
    input logic aux_frame_sync_oe_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_always_okay_a:
        assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    main_oe_pair_a:
        assert property (main_bclk_oe_n == main_fclk_oe_n) else $error("main clock enables split");
    aux_oe_pair_a:
        assert property (aux_bit_clock_oe_n == aux_frame_sync_oe_n) else $error("aux enables split");
    bclk_high_half_a:
        assert property ($rose(main_bclk_o) |-> main_bclk_o[*4]) else $error("bit clock high too short");
    bclk_low_half_a:
        assert property ($fell(main_bclk_o) |-> !main_bclk_o[*4]) else $error("bit clock low too short");
    fclk_on_low_a:
        assert property ($changed(main_fclk_o) |-> !main_bclk_o) else $error("frame clock moved high");
    sdo_on_low_a:
        assert property ($changed(main_serial_out) && $stable(main_serial_out_oe_n) |-> !main_bclk_o)
            else $error("serial out moved while bit clock high");
    aux_clock_steady_a:
        assert property ($changed(aux_bit_clock_o) |=> $stable(aux_bit_clock_o)[*3])
            else $error("aux bit clock half too short");
    cover property ($rose(main_bclk_o));
    cover property ($fell(main_serial_out_oe_n));
    cover property ($rose(aux_bit_clock_o));
endmodule // dasp_props

bind dasp_top dasp_props u_dasp_props (.*);

// ---- verif/dasp_codec.sv ----
// Behavioural external audio codec on the main port
`timescale 1ns/10ps
module dasp_codec (
    // Bench control
    input  logic        run,
    input  logic [5:0]  half,
    input  logic [15:0] tx_l,
    input  logic [15:0] tx_r,
    // Line side
    input  logic        bclk,
    input  logic        fclk,
    input  logic        sd_in,
    output logic        bclk_o = 1'b0,
    output logic        fclk_o = 1'b0,
    output logic        sd_o = 1'b0,
    // Captured phases
    output logic [31:0] hi_half,
    output logic [31:0] lo_half
);
    int          n = 0;
    int          k = 0;
    logic        pf = 1'b0;
    logic [31:0] cap = 32'h0;
    always begin
        if (run !== 1'b1) begin
            wait (run === 1'b1);
            #13;
        end
        #200 bclk_o = 1'b1;
        #200 bclk_o = 1'b0;
        k = (k + 1) % half;
        if (k == 0) fclk_o = ~fclk_o;
    end
    always @(negedge bclk) begin
        #1;
        n = (fclk != pf) ? 0 : n + 1;
        pf = fclk;
        sd_o = (n < 16) ? (fclk ? tx_l[15 - n] : tx_r[15 - n]) : ~sd_o;
    end
    always @(posedge bclk) cap = {cap[30:0], sd_in};
    always @(fclk) begin
        if (fclk) lo_half = cap;
        else hi_half = cap;
    end
endmodule // dasp_codec

// ---- verif/dasp_top_bench.sv ----
// Bench for the dual audio serial port
`timescale 1ns/10ps
module dasp_top_bench;
    import dasp_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, run;
    logic [31:0] haddr, hwdata, hrdata, q, hi_half, lo_half;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [5:0]  half;
    logic [15:0] cl, cr;
    logic        cb, cf, cs, main_bclk_o, main_bclk_oe_n, main_fclk_o, main_fclk_oe_n;
    logic        main_serial_out, main_serial_out_oe_n, aux_bit_clock_o, aux_bit_clock_oe_n;
    logic        aux_frame_sync_o, aux_frame_sync_oe_n, aux_serial_out, aux_serial_out_oe_n;
    wire         hready = hreadyout;
    wire         bclk = main_bclk_oe_n ? cb : main_bclk_o;
    wire         fclk = main_fclk_oe_n ? cf : main_fclk_o;
    wire         aux_serial_in = aux_serial_out;
    int          num_errors = 0, total_checks = 0;
    int          hl[3] = '{32, 20, 16};
    int          fm[3] = '{0, 2, 5};
    int          ms[3] = '{15, 31, 30};
    dasp_top u_dasp_top (.*, .main_bclk_i(bclk), .main_fclk_i(fclk), .main_serial_in(cs),
        .aux_bit_clock_i(1'b0), .aux_frame_sync_i(1'b0));
    dasp_codec u_dasp_codec (.run, .half, .tx_l(cl), .tx_r(cr), .bclk, .fclk,
        .sd_in(main_serial_out), .bclk_o(cb), .fclk_o(cf), .sd_o(cs), .hi_half, .lo_half);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
        q = hrdata;
        if (n >= 50) num_errors++;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        #2_000_000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, run} = '0;
        hsize = 3'h2;
        half = 6'd32;
        cl = 16'h8E31;
        cr = 16'h4C7A;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({main_bclk_oe_n, main_serial_out_oe_n, aux_bit_clock_oe_n, aux_serial_out_oe_n}, 15);
        bus(1'b0, SAMP_CFG_OFF, 0);
        chk(q[4:0], FLEN_RST);
        bus(1'b0, 8'h3C, 0);
        chk(q, 0);
        bus(1'b1, MAIN_FMT_OFF, 32'h2);
        bus(1'b0, MAIN_FMT_OFF, 0);
        chk(q[2:0], 3'h2);
        $display("test registers done");
        bus(1'b1, MAIN_CTL_OFF, 32'h1);
        foreach (hl[i]) begin
            cl = ~cl;
            half <= 6'(hl[i]);
            bus(1'b1, SAMP_CFG_OFF, 32'(hl[i] - 1));
            run <= 1'b1;
            repeat (1400) @(posedge hclk);
            bus(1'b0, MAIN_RXL_OFF, 0);
            chk(q[15:0], cl);
            bus(1'b0, MAIN_RXR_OFF, 0);
            chk(q[15:0], cr);
            chk(main_bclk_oe_n, 1);
            run <= 1'b0;
        end
        $display("test slave receive done");
        bus(1'b1, SAMP_CFG_OFF, 32'h1F);
        bus(1'b1, MAIN_CTL_OFF, 32'h4);
        repeat (40) @(posedge hclk);
        chk({main_bclk_oe_n, main_bclk_o, main_fclk_o}, 0);
        bus(1'b1, MAIN_TXL_OFF, 32'hA5C3);
        bus(1'b1, MAIN_TXR_OFF, 32'h3C5A);
        bus(1'b1, MAIN_CTL_OFF, 32'h7);
        foreach (fm[i]) begin
            @(negedge main_bclk_o);
            bus(1'b1, MAIN_FMT_OFF, 32'(fm[i]));
            repeat (1200) @(posedge hclk);
            chk(fm[i][0] ? lo_half[ms[i] -: 16] : hi_half[ms[i] -: 16], 16'hA5C3);
            chk(fm[i][0] ? hi_half[ms[i] -: 16] : lo_half[ms[i] -: 16], 16'h3C5A);
            if (i == 0) chk(hi_half[31:16], 0);
        end
        chk({main_bclk_oe_n, main_serial_out_oe_n}, 0);
        bus(1'b0, STATUS_OFF, 0);
        chk(q[0], 1);
        $display("test master transmit done");
        bus(1'b1, AUX_CFG_OFF, 32'h822);
        bus(1'b1, AUX_TX_OFF, 32'h6B19);
        bus(1'b1, AUX_CTL_OFF, 32'h7);
        repeat (2600) @(posedge hclk);
        bus(1'b0, AUX_RX_OFF, 0);
        chk(q[15:0], 16'h6B19);
        chk({aux_bit_clock_oe_n, aux_serial_out_oe_n}, 0);
        bus(1'b0, AUX_CFG_OFF, 0);
        chk(q[11:0], 12'h822);
        $display("test aux port done");
        report_and_stop;
    end
endmodule // dasp_top_bench
